// [hdl/ranging_addr_peak_regs.sv]
// Address unlock, address response, alternate status, threshold override and peak list readout.
//
// Operation
// - An 8-bit read/write register holds the alternate bus address.
// - Alternate address answers only while both unlock bytes match the serial number.
// - Override zero selects the normal validity judgement.
// - Nonzero override becomes a simple threshold on the peak for validity.
// - Alternate status on: status reads all ones except the selected zero bit.
// - Alternate status off: the normal status byte is presented.
// - A configuration bit enables or disables the alternate address.
// - Suppress clear: answer the default address and a valid alternate address.
// - Suppress set: ignore the default address, answer only the alternate one.
// - Reading the peak upper register latches the low byte and advances the pointer.
// - Writing one to the peak upper register rewinds the pointer to the start.
// - Reading the peak lower register returns the latched low byte.
// - The serial number reads back as two read-only bytes used for unlocking.
`timescale 1ns/1ps
`default_nettype none
module ranging_addr_peak_regs
  import ranging_regs_pkg::*;
#(
  parameter int PEAK_PTR_W = 5
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  input  wire logic [15:0]             serial_number,
  input  wire logic [7:0]              status_normal,
  input  wire logic [PEAK_ENTRY_W-1:0] peak_entry,
  output logic [PEAK_PTR_W-1:0]        peak_index,
  input  wire logic [PEAK_ENTRY_W-1:0] meas_peak,
  input  wire logic                    default_valid,
  output logic                         meas_valid,
  output logic [7:0]                   threshold_override
);

  reg_access_if bus ();

  logic [7:0] unlock_upper_reg;
  logic [7:0] unlock_lower_reg;
  logic [7:0] alt_addr_reg;
  logic [7:0] config_reg;
  logic [7:0] peak_low_reg;
  logic       unlocked;
  logic       alt_match;
  logic       def_match;
  logic [7:0] alt_status;
  logic [7:0] rdata_next;

  serial_bus_target u_target (
    .clk     (clk),
    .reset   (reset),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .bus     (bus.target)
  );

  // ----------------------------------------------------------------
  // Bus address response
  // ----------------------------------------------------------------
  // The alternate address is the low seven bits of its register; even values are the host's duty.
  assign unlocked  = (unlock_upper_reg == serial_number[15:8]) &&
                     (unlock_lower_reg == serial_number[7:0]);
  assign alt_match = config_reg[CFG_ALT_ADDR_EN_BIT] && unlocked &&
                     (bus.dev_addr == alt_addr_reg[6:0]);
  assign def_match = !config_reg[CFG_SUPPRESS_DEF_BIT] &&
                     (bus.dev_addr == DEFAULT_BUS_ADDRESS);
  assign bus.addr_hit = def_match || alt_match;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      unlock_upper_reg   <= RST_UNLOCK;
      unlock_lower_reg   <= RST_UNLOCK;
      alt_addr_reg       <= RST_ALT_BUS_ADDRESS;
      threshold_override <= RST_THRESHOLD;
      config_reg         <= RST_ADDR_RESP_CONFIG;
    end else if (bus.wr_stb) begin
      case (bus.reg_addr)
        OFS_UNLOCK_UPPER:      unlock_upper_reg   <= bus.wdata;
        OFS_UNLOCK_LOWER:      unlock_lower_reg   <= bus.wdata;
        OFS_ALT_BUS_ADDRESS:   alt_addr_reg       <= bus.wdata;
        OFS_THRESHOLD_OVERIDE: threshold_override <= bus.wdata;
        OFS_ADDR_RESP_CONFIG:  config_reg         <= bus.wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Peak list pointer and low byte latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      peak_index   <= '0;
      peak_low_reg <= RST_PEAK_LOW;
    end else if (bus.rd_stb && (bus.reg_addr == OFS_PEAK_LIST_UPPER)) begin
      peak_low_reg <= peak_entry[7:0];
      peak_index   <= peak_index + 1'b1;
    end else if (bus.wr_stb && (bus.reg_addr == OFS_PEAK_LIST_UPPER) &&
                 (bus.wdata == PEAK_REWIND_VALUE)) begin
      peak_index <= '0;
    end else if (bus.wr_stb && (bus.reg_addr == OFS_PEAK_LIST_LOWER)) begin
      peak_low_reg <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Measurement validity
  // ----------------------------------------------------------------
  // Registered so the measurement engine sees a clean level one cycle after its inputs.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meas_valid <= 1'b0;
    end else if (threshold_override == 8'h00) begin
      meas_valid <= default_valid;
    end else begin
      meas_valid <= (meas_peak >= PEAK_ENTRY_W'(threshold_override));
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign alt_status = ~(ALT_STATUS_BASE << config_reg[CFG_SEL_MSB:0]);

  always_comb begin
    rdata_next = UNMAPPED_READBACK;
    case (bus.reg_addr)
      OFS_STATUS: begin
        if (config_reg[CFG_ALT_STATUS_BIT]) begin
          rdata_next = alt_status;
        end else begin
          rdata_next = status_normal;
        end
      end
      OFS_SERIAL_UPPER:      rdata_next = serial_number[15:8];
      OFS_SERIAL_LOWER:      rdata_next = serial_number[7:0];
      OFS_UNLOCK_UPPER:      rdata_next = WRITE_ONLY_READBACK;
      OFS_UNLOCK_LOWER:      rdata_next = WRITE_ONLY_READBACK;
      OFS_ALT_BUS_ADDRESS:   rdata_next = alt_addr_reg;
      OFS_THRESHOLD_OVERIDE: rdata_next = threshold_override;
      OFS_ADDR_RESP_CONFIG:  rdata_next = config_reg;
      OFS_PEAK_LIST_UPPER:   rdata_next = {5'h00, peak_entry[10:8]};
      OFS_PEAK_LIST_LOWER:   rdata_next = peak_low_reg;
      default:               rdata_next = UNMAPPED_READBACK;
    endcase
  end

  assign bus.rdata = rdata_next;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_upper_read;
    bus.rd_stb && (bus.reg_addr == OFS_PEAK_LIST_UPPER);
  endsequence

  sequence s_rewind_write;
    bus.wr_stb && (bus.reg_addr == OFS_PEAK_LIST_UPPER) && (bus.wdata == PEAK_REWIND_VALUE);
  endsequence

  sequence s_lower_read;
    bus.rd_stb && (bus.reg_addr == OFS_PEAK_LIST_LOWER);
  endsequence

  // Upper and lower reads sit a whole byte apart on the wire, far beyond any repetition count.
  // A separate copy of the expected low byte therefore follows upper reads and lower writes.
  logic [7:0] peak_low_check_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      peak_low_check_reg <= RST_PEAK_LOW;
    end else if (bus.rd_stb && (bus.reg_addr == OFS_PEAK_LIST_UPPER)) begin
      peak_low_check_reg <= peak_entry[7:0];
    end else if (bus.wr_stb && (bus.reg_addr == OFS_PEAK_LIST_LOWER)) begin
      peak_low_check_reg <= bus.wdata;
    end
  end

  a_peak_ptr_advance: assert property (s_upper_read |=>
      peak_index == $past(peak_index) + 1'b1)
    else $error("Peak pointer did not advance after upper read.");

  a_peak_low_latch: assert property (s_upper_read |=>
      peak_low_reg == $past(peak_entry[7:0]))
    else $error("Peak low byte was not latched on upper read.");

  a_peak_ptr_rewind: assert property (s_rewind_write |=> peak_index == '0)
    else $error("Peak pointer did not rewind on write of one.");

  a_peak_low_read: assert property (s_lower_read |->
      bus.rdata == peak_low_check_reg)
    else $error("Peak lower read does not return the latched byte.");

  a_alt_status_on: assert property (config_reg[CFG_ALT_STATUS_BIT] &&
      bus.reg_addr == OFS_STATUS |-> $countones(bus.rdata) == 7 &&
      !bus.rdata[config_reg[CFG_SEL_MSB:0]])
    else $error("Alternate status byte has wrong shape.");

  a_alt_status_off: assert property (!config_reg[CFG_ALT_STATUS_BIT] &&
      bus.reg_addr == OFS_STATUS |-> bus.rdata == status_normal)
    else $error("Normal status byte not presented.");

  a_default_answer: assert property (!config_reg[CFG_SUPPRESS_DEF_BIT] &&
      bus.dev_addr == DEFAULT_BUS_ADDRESS |-> bus.addr_hit)
    else $error("Default address not answered.");

  a_default_ignored: assert property (config_reg[CFG_SUPPRESS_DEF_BIT] &&
      !alt_match |-> !bus.addr_hit)
    else $error("Address answered while default is suppressed.");

  a_alt_locked: assert property ((!unlocked ||
      !config_reg[CFG_ALT_ADDR_EN_BIT]) && bus.dev_addr != DEFAULT_BUS_ADDRESS |-> !bus.addr_hit)
    else $error("Alternate address answered while locked or disabled.");

  a_alt_addr_store: assert property (bus.wr_stb &&
      bus.reg_addr == OFS_ALT_BUS_ADDRESS |=> alt_addr_reg == $past(bus.wdata))
    else $error("Alternate address register did not store the write.");

  a_thresh_default: assert property (threshold_override == 8'h00 |=>
      meas_valid == $past(default_valid))
    else $error("Normal validity not used with zero override.");

  a_thresh_simple: assert property (threshold_override != 8'h00 |=>
      meas_valid == ($past(meas_peak) >= PEAK_ENTRY_W'($past(threshold_override))))
    else $error("Simple threshold not applied.");

  a_unlock_readback: assert property (bus.rd_stb &&
      bus.reg_addr == OFS_UNLOCK_UPPER |-> bus.rdata == WRITE_ONLY_READBACK
      ##1 $stable(unlock_upper_reg))
    else $error("Unlock register read returned data or changed state.");

endmodule
`default_nettype wire

// [hdl/ranging_regs_pkg.sv]
// Package with register offsets, field positions and reset values of the ranging register bank.
package ranging_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS            = 8'h01;
  localparam logic [7:0] OFS_SERIAL_UPPER      = 8'h16;
  localparam logic [7:0] OFS_SERIAL_LOWER      = 8'h17;
  localparam logic [7:0] OFS_UNLOCK_UPPER      = 8'h18;
  localparam logic [7:0] OFS_UNLOCK_LOWER      = 8'h19;
  localparam logic [7:0] OFS_ALT_BUS_ADDRESS   = 8'h1A;
  localparam logic [7:0] OFS_THRESHOLD_OVERIDE = 8'h1C;
  localparam logic [7:0] OFS_ADDR_RESP_CONFIG  = 8'h1E;
  localparam logic [7:0] OFS_PEAK_LIST_UPPER   = 8'h26;
  localparam logic [7:0] OFS_PEAK_LIST_LOWER   = 8'h27;

  // ----------------------------------------------------------------
  // Fields and constants
  // ----------------------------------------------------------------
  localparam int         CFG_ALT_STATUS_BIT   = 5;
  localparam int         CFG_ALT_ADDR_EN_BIT  = 4;
  localparam int         CFG_SUPPRESS_DEF_BIT = 3;
  localparam int         CFG_SEL_MSB          = 2;
  localparam logic [6:0] DEFAULT_BUS_ADDRESS  = 7'h62;
  localparam logic [7:0] PEAK_REWIND_VALUE    = 8'h01;
  localparam logic [7:0] ALT_STATUS_BASE      = 8'h01;
  localparam logic [7:0] WRITE_ONLY_READBACK  = 8'h00;
  localparam logic [7:0] UNMAPPED_READBACK    = 8'h00;
  localparam int         PEAK_ENTRY_W         = 11;
  localparam int         BYTE_BITS            = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_UNLOCK           = 8'h00;
  localparam logic [7:0] RST_ALT_BUS_ADDRESS  = 8'h00;
  localparam logic [7:0] RST_THRESHOLD        = 8'h00;
  localparam logic [7:0] RST_ADDR_RESP_CONFIG = 8'h00;
  localparam logic [7:0] RST_PEAK_LOW         = 8'h00;

endpackage

// [hdl/reg_access_if.sv]
// Interface carrying register accesses from the bus target to the register bank.
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic [6:0] dev_addr;
  logic       addr_hit;
  logic [7:0] reg_addr;
  logic       wr_stb;
  logic [7:0] wdata;
  logic       rd_stb;
  logic [7:0] rdata;

  modport target (output dev_addr, output reg_addr, output wr_stb, output wdata,
                  output rd_stb, input addr_hit, input rdata);
  modport bank   (input dev_addr, input reg_addr, input wr_stb, input wdata,
                  input rd_stb, output addr_hit, output rdata);
endinterface
`default_nettype wire

// [hdl/serial_bus_target.sv]
// Two-wire serial bus target: address match, register pointer, byte writes and reads.
`timescale 1ns/1ps
`default_nettype none
module serial_bus_target
  import ranging_regs_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_out,
  output logic        sda_oe,
  reg_access_if.target bus
);

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_PTR      = 3'b011,
    ST_WDATA    = 3'b100,
    ST_WACK     = 3'b101,
    ST_RDATA    = 3'b110,
    ST_RACK     = 3'b111
  } bus_state_e;

  bus_state_e state_reg;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [3:0] cnt_reg;
  logic       rw_reg;
  logic       nack_reg;
  logic [7:0] ptr_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       byte_done;
  logic       ptr_load;

  // ----------------------------------------------------------------
  // Line edges and bus conditions
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
  assign byte_done  = scl_fall && (cnt_reg == 4'(BYTE_BITS));
  assign ptr_load   = byte_done && (state_reg == ST_PTR);

  assign bus.dev_addr = shift_reg[7:1];
  assign bus.wdata    = shift_reg;
  assign bus.reg_addr = ptr_reg;
  assign bus.wr_stb   = byte_done && (state_reg == ST_WDATA);
  assign bus.rd_stb   = scl_fall && (((state_reg == ST_ADDR_ACK) && rw_reg) ||
                                     ((state_reg == ST_RACK) && !nack_reg));
  // The line is open drain: only a low level is ever driven.
  assign sda_out      = 1'b0;

  // ----------------------------------------------------------------
  // Register pointer, advanced after every data byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_reg <= 8'h00;
    end else if (ptr_load) begin
      ptr_reg <= shift_reg;
    end else if (bus.wr_stb || bus.rd_stb) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      tx_reg    <= 8'h00;
      cnt_reg   <= 4'h0;
      rw_reg    <= 1'b0;
      nack_reg  <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (start_cond) begin
      state_reg <= ST_ADDR;
      cnt_reg   <= 4'h0;
      sda_oe    <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= ST_IDLE;
      sda_oe    <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise && (cnt_reg < 4'(BYTE_BITS))) begin
            shift_reg <= {shift_reg[6:0], sda_in};
            cnt_reg   <= cnt_reg + 4'h1;
          end
          if (byte_done) begin
            cnt_reg <= 4'h0;
            if (state_reg != ST_ADDR) begin
              sda_oe    <= 1'b1;
              state_reg <= ST_WACK;
            end else if (bus.addr_hit) begin
              sda_oe    <= 1'b1;
              rw_reg    <= shift_reg[0];
              state_reg <= ST_ADDR_ACK;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              tx_reg    <= bus.rdata;
              sda_oe    <= ~bus.rdata[7];
              cnt_reg   <= 4'h1;
              state_reg <= ST_RDATA;
            end else begin
              sda_oe    <= 1'b0;
              state_reg <= ST_PTR;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe    <= 1'b0;
            state_reg <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (byte_done) begin
            sda_oe    <= 1'b0;
            state_reg <= ST_RACK;
          end else if (scl_fall) begin
            tx_reg  <= {tx_reg[6:0], 1'b0};
            sda_oe  <= ~tx_reg[6];
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nack_reg <= sda_in;
          end
          if (scl_fall) begin
            if (nack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              tx_reg    <= bus.rdata;
              sda_oe    <= ~bus.rdata[7];
              cnt_reg   <= 4'h1;
              state_reg <= ST_RDATA;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [testbench/i2c_host_model.sv]
// Behavioural two-wire bus host that drives the clock line and pulls the data line.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  logic r;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Each phase spans three clocks, so the target samples every level at least twice.
  task automatic ph;
    repeat (3) @(posedge clk);
    #2;
  endtask

  task automatic start;
    sda_drv = 1'b1;
    ph;
    scl = 1'b1;
    ph;
    sda_drv = 1'b0;
    ph;
    scl = 1'b0;
    ph;
  endtask

  task automatic stop;
    sda_drv = 1'b0;
    ph;
    scl = 1'b1;
    ph;
    sda_drv = 1'b1;
    ph;
  endtask

  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    ph;
    scl = 1'b1;
    ph;
    s = sda;
    ph;
    scl = 1'b0;
    ph;
  endtask

  // Sends d most significant bit first, returns the bits seen and the ninth-bit acknowledge.
  task automatic xfer(input logic [7:0] d, input logic a9, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(a9, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the ranging register bank reached over its serial port.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ranging_regs_pkg::*;
  localparam int         PW  = 5;
  localparam logic [6:0] DEF = DEFAULT_BUS_ADDRESS;
  localparam logic [6:0] ALT = 7'h22;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        scl, sda_drv, sda, sda_out, sda_oe, default_valid, meas_valid;
  logic [15:0] serial_number;
  logic [7:0]  status_normal, threshold_override, m_thr;
  logic [10:0] peak_entry, meas_peak;
  logic [10:0] peak_mem [32];
  logic [PW-1:0] peak_index;
  logic [7:0]  rq [$];
  integer      failures = 0;
  integer      samples_checked = 0;
  integer      seed = 98;

  always #12.5 clk = ~clk;
  // Pull-up wire: low whenever either party pulls it.
  assign sda = sda_drv & (~sda_oe | sda_out);
  assign peak_entry = peak_mem[peak_index];

  ranging_addr_peak_regs #(.PEAK_PTR_W(PW)) i_ranging_addr_peak_regs (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .serial_number(serial_number), .status_normal(status_normal),
    .peak_entry(peak_entry), .peak_index(peak_index), .meas_peak(meas_peak),
    .default_valid(default_valid), .meas_valid(meas_valid),
    .threshold_override(threshold_override));
  i2c_host_model i_i2c_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_byte(n, {7'h00, e}, {7'h00, g});
  endtask

  task automatic open(input logic [6:0] dev, input logic ok, output logic a);
    logic [7:0] q;
    i_i2c_host_model.start;
    i_i2c_host_model.xfer({dev, 1'b0}, 1'b1, q, a);
    chk_bit("address ack", ok, a);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                    input logic ok);
    logic [7:0] q;
    logic       a;
    open(dev, ok, a);
    if (a === 1'b1) begin
      i_i2c_host_model.xfer(ofs, 1'b1, q, a);
      i_i2c_host_model.xfer(d, 1'b1, q, a);
      chk_bit("data ack", 1'b1, a);
    end
    i_i2c_host_model.stop;
  endtask

  // Pointer write, then a repeated start and n read bytes, the last one refused by the host.
  task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, input int n, input logic ok);
    logic [7:0] q;
    logic       a;
    rq.delete();
    open(dev, ok, a);
    if (a === 1'b1) begin
      i_i2c_host_model.xfer(ofs, 1'b1, q, a);
      i_i2c_host_model.start;
      i_i2c_host_model.xfer({dev, 1'b1}, 1'b1, q, a);
      for (int i = 0; i < n; i++) begin
        i_i2c_host_model.xfer(8'hFF, i == n - 1, q, a);
        rq.push_back(q);
      end
    end
    i_i2c_host_model.stop;
  endtask

  task automatic rd1(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] e);
    rd(dev, ofs, 1, 1'b1);
    chk_byte($sformatf("register %h", ofs), e, rq[0]);
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    serial_number = 16'($random(seed));
    status_normal = 8'($random(seed));
    meas_peak = 11'h000;
    default_valid = 1'b0;
    for (int i = 0; i < 32; i++) peak_mem[i] = 11'($random(seed));
    repeat (8) @(posedge clk);
    #2;
    reset = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    rd1(DEF, OFS_THRESHOLD_OVERIDE, RST_THRESHOLD);
    rd1(DEF, OFS_ADDR_RESP_CONFIG, RST_ADDR_RESP_CONFIG);
    rd(DEF, OFS_SERIAL_UPPER, 2, 1'b1);
    chk_byte("serial upper", serial_number[15:8], rq[0]);
    chk_byte("serial lower", serial_number[7:0], rq[1]);
    wr(DEF, OFS_SERIAL_UPPER, ~serial_number[15:8], 1'b1);
    rd1(DEF, OFS_SERIAL_UPPER, serial_number[15:8]);
    rd1(DEF, 8'h30, UNMAPPED_READBACK);
    wr(DEF, OFS_ALT_BUS_ADDRESS, {1'b0, ALT}, 1'b1);
    rd1(DEF, OFS_ALT_BUS_ADDRESS, {1'b0, ALT});
    wr(DEF, OFS_ADDR_RESP_CONFIG, 8'h10, 1'b1);
    wr(DEF, OFS_UNLOCK_UPPER, serial_number[15:8], 1'b1);
    wr(DEF, OFS_UNLOCK_LOWER, ~serial_number[7:0], 1'b1);
    rd(ALT, OFS_STATUS, 1, 1'b0);
    wr(DEF, OFS_UNLOCK_LOWER, serial_number[7:0], 1'b1);
    rd1(DEF, OFS_UNLOCK_UPPER, WRITE_ONLY_READBACK);
    rd1(DEF, OFS_UNLOCK_LOWER, WRITE_ONLY_READBACK);
    rd1(ALT, OFS_STATUS, status_normal);
    rd1(DEF, OFS_ADDR_RESP_CONFIG, 8'h10);
    wr(ALT, OFS_ADDR_RESP_CONFIG, 8'h18, 1'b1);
    rd(DEF, OFS_STATUS, 1, 1'b0);
    rd1(ALT, OFS_ADDR_RESP_CONFIG, 8'h18);
    wr(ALT, OFS_ADDR_RESP_CONFIG, 8'h00, 1'b1);
    rd(ALT, OFS_STATUS, 1, 1'b0);
    for (int s = 0; s < 8; s++) begin
      wr(DEF, OFS_ADDR_RESP_CONFIG, 8'h20 | s[7:0], 1'b1);
      rd1(DEF, OFS_STATUS, ~(8'h01 << s));
    end
    wr(DEF, OFS_ADDR_RESP_CONFIG, 8'h07, 1'b1);
    rd1(DEF, OFS_STATUS, status_normal);
    for (int k = 0; k < 6; k++) begin
      m_thr = (k == 0) ? 8'h00 : (k == 1) ? 8'h40 : 8'($random(seed));
      wr(DEF, OFS_THRESHOLD_OVERIDE, m_thr, 1'b1);
      for (int j = 0; j < 4; j++) begin
        meas_peak = (j == 0) ? {3'b000, m_thr} : (j == 1) ? {3'b000, m_thr} - 11'h001
                  : {3'b000, 8'($random(seed))};
        default_valid = j[0];
        repeat (3) @(posedge clk);
        #2;
        chk_bit("valid", (m_thr == 8'h00) ? default_valid : meas_peak >= m_thr,
                meas_valid);
      end
      chk_byte("override", m_thr, threshold_override);
    end
    wr(DEF, OFS_PEAK_LIST_UPPER, PEAK_REWIND_VALUE, 1'b1);
    for (int p = 0; p < 3; p++) begin
      rd(DEF, OFS_PEAK_LIST_UPPER, 2, 1'b1);
      chk_byte("peak upper", {5'b00000, peak_mem[p][10:8]}, rq[0]);
      chk_byte("peak lower", peak_mem[p][7:0], rq[1]);
    end
    wr(DEF, OFS_PEAK_LIST_UPPER, 8'h02, 1'b1);
    chk_byte("index", 8'h03, 8'(peak_index));
    wr(DEF, OFS_PEAK_LIST_UPPER, PEAK_REWIND_VALUE, 1'b1);
    chk_byte("index", 8'h00, 8'(peak_index));
    rd1(DEF, OFS_PEAK_LIST_UPPER, {5'b00000, peak_mem[0][10:8]});
    rd1(DEF, OFS_PEAK_LIST_LOWER, peak_mem[0][7:0]);
    results;
  end

  // The sequence needs well under one millisecond; twice that means a hang.
  initial begin
    #2000000;
    failures++;
    results;
  end
endmodule
`default_nettype wire
